// file: cbf_pkg.sv
`default_nettype none
package cbf_pkg;
  // current magnitudes are unsigned counts of 0.001 x nominal current
  localparam int unsigned MAG_W = 16;
  // delays are counts of 5 ms program-cycle ticks
  localparam int unsigned DLY_W = 19;
  localparam int unsigned TICK_MS = 5;
  localparam int unsigned CLK_HZ = 20000000;
  // program-cycle length in clocks, derived from the tick time and the clock rate
  localparam int unsigned TICK_CYC = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned TCNT_W = 17;
  // setting steps, in magnitude units
  localparam logic [MAG_W-1:0] PH_STEP = 16'h000A;
  localparam logic [MAG_W-1:0] RES_STEP = 16'h0001;
  // defaults: phase 0.20 In, residual 1.200 In
  localparam logic [MAG_W-1:0] PH_SET_RST = 16'h00C8;
  localparam logic [MAG_W-1:0] RES_SET_RST = 16'h04B0;
  // defaults: retrip 0.100 s = 20 ticks, breaker failure 0.200 s = 40 ticks
  localparam logic [DLY_W-1:0] RETRIP_RST = 19'h00014;
  localparam logic [DLY_W-1:0] BF_RST = 19'h00028;
  // release ratio 97 percent, applied as value * 97 / 100
  localparam int unsigned REL_NUM = 97;
  localparam int unsigned REL_DEN = 100;
  // residual source selection
  typedef enum logic [1:0] {
    RES_OFF = 2'h0,
    RES_ONE = 2'h1,
    RES_TWO = 2'h2,
    RES_CALC = 2'h3
  } res_sel_t;
  // operating mode bits: [0] current, [1] signal, [2] output relay, [3] 1 = and, 0 = or
  localparam int unsigned MODE_CUR = 0;
  localparam int unsigned MODE_SIG = 1;
  localparam int unsigned MODE_DO = 2;
  localparam int unsigned MODE_AND = 3;
  localparam logic [3:0] MODE_RST = 4'h1;
  // condition indication
  typedef enum logic [2:0] {
    COND_NORMAL = 3'h0,
    COND_START = 3'h1,
    COND_RETRIP = 3'h2,
    COND_BF = 3'h3,
    COND_BLOCKED = 3'h4
  } cond_t;
endpackage
`default_nettype wire

// file: breaker_failure_protection.sv
// Function
// - compare each phase and residual to threshold
// - drop out below 97 percent of threshold
// - one phase threshold, any phase picks up
// - residual source select, default not used
// - mode selects current/signal/relay and/or combos
// - phase threshold steps 0.01, default 0.20
// - residual threshold steps 0.001, default 1.200
// - readable condition: normal/start/retrip/failure/blocked
// - sample block input at cycle start
// - unblocked pick-up asserts start, starts timing
// - blocked pick-up shows blocked, no timing
// - late blocking drops start, releases timers
// - one pick-up starts both timers
// - retrip enable, default on, disables output
// - retrip after retrip delay, 5 ms steps
// - failure output after failure delay, default 0.2s
// - current mode runs on current only
// - current-and-relay waits for relay, clears either
// - current-or-relay clears only when both end
// - settings accepted while running
// - magnitudes refreshed on 5 ms base
// - forcing overrides condition indication
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
`default_nettype none
module breaker_failure_protection
  import cbf_pkg::*;
#(
  // program-cycle length in clocks, shortened only by test benches
  parameter int unsigned TICK_LEN = TICK_CYC
)
(
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // magnitudes from the measurement front end, same clock
  input wire logic [MAG_W-1:0] phase_a_mag_in,
  input wire logic [MAG_W-1:0] phase_b_mag_in,
  input wire logic [MAG_W-1:0] phase_c_mag_in,
  input wire logic [MAG_W-1:0] residual_input_one_in,
  input wire logic [MAG_W-1:0] residual_input_two_in,
  input wire logic [MAG_W-1:0] calculated_residual_in,
  // external binary signals, asynchronous
  input wire logic block_in,
  input wire logic signal_trip_in,
  input wire logic relay_trip_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // protection outputs
  output logic start_out,
  output logic retrip_out,
  output logic breaker_failure_output_out,
  output logic blocked_out,
  output logic tick_out,
  output logic [2:0] condition_out
);

  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PH_SET = 4'h4;
  localparam logic [3:0] REG_RES_SET = 4'h8;
  localparam logic [3:0] REG_RETRIP = 4'hC;
  // second bank via bit offsets within the same word window is avoided: status shares CTRL reads
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // control word field positions
  localparam int unsigned F_MODE = 0;
  localparam int unsigned F_RES = 4;
  localparam int unsigned F_RT_EN = 6;
  localparam int unsigned F_FRC_EN = 7;
  localparam int unsigned F_FRC = 8;
  localparam int unsigned F_BF = 12;
  localparam int unsigned F_COND = 16;

  // all state in one struct
  typedef struct packed {
    logic [2:0] blk_s;        // block synchroniser, [0] first stage
    logic [2:0] sig_s;        // signal synchroniser
    logic [2:0] rly_s;        // relay synchroniser
    logic [TCNT_W-1:0] tcnt;  // program-cycle divider
    logic tick;               // program-cycle pulse
    logic blk;                // block sampled at cycle start
    logic [3:0] pu;           // per-element picked-up state, [3] residual
    logic start;
    logic blocked;
    logic [DLY_W-1:0] rt_cnt; // retrip timer
    logic [DLY_W-1:0] bf_cnt; // failure timer
    logic retrip;
    logic bf;
    logic [3:0] mode;
    res_sel_t res_sel;
    logic rt_en;
    logic frc_en;
    cond_t frc;
    logic [MAG_W-1:0] ph_set;
    logic [MAG_W-1:0] res_set;
    logic [DLY_W-1:0] rt_dly;
    logic [DLY_W-1:0] bf_dly;
    logic ack;                // bus answer stage
    logic [31:0] rdata;
  } state_t;

  state_t s_q, s_d;
  logic [MAG_W-1:0] mag [4];  // element magnitudes
  logic [MAG_W-1:0] thr [4];  // element thresholds
  logic [3:0] pu_n;           // next pick-up per element
  logic cur_pu, crit, pickup;
  cond_t cond;

  assign mag[0] = phase_a_mag_in;
  assign mag[1] = phase_b_mag_in;
  assign mag[2] = phase_c_mag_in;
  assign thr[0] = s_q.ph_set;
  assign thr[1] = s_q.ph_set;
  assign thr[2] = s_q.ph_set;
  assign thr[3] = s_q.res_set;

  // residual source selection
  always_comb begin
    unique case (s_q.res_sel)
      RES_ONE: mag[3] = residual_input_one_in;
      RES_TWO: mag[3] = residual_input_two_in;
      RES_CALC: mag[3] = calculated_residual_in;
      RES_OFF: mag[3] = '0;
    endcase
  end

  // per-element pick-up with 97 percent release
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_elem
    logic [MAG_W+7:0] rel_lim;
    assign rel_lim = (MAG_W+8)'((32'(thr[gi]) * REL_NUM) / REL_DEN);
    always_comb begin
      if (gi == 3 && s_q.res_sel == RES_OFF) begin
        pu_n[gi] = 1'b0;
      end else if (mag[gi] > thr[gi]) begin
        pu_n[gi] = 1'b1;
      end else if ((MAG_W+8)'(mag[gi]) < rel_lim) begin
        pu_n[gi] = 1'b0;
      end else begin
        pu_n[gi] = s_q.pu[gi];
      end
    end
  end

  // combine criteria per operating mode
  always_comb begin
    logic c_ok, s_ok, d_ok, c_or, s_or, d_or;
    c_ok = 1'b1;
    s_ok = 1'b1;
    d_ok = 1'b1;
    c_or = 1'b0;
    s_or = 1'b0;
    d_or = 1'b0;
    cur_pu = |s_q.pu;
    if (s_q.mode[MODE_CUR]) begin
      c_ok = cur_pu;
      c_or = cur_pu;
    end
    if (s_q.mode[MODE_SIG]) begin
      s_ok = s_q.sig_s[2];
      s_or = s_q.sig_s[2];
    end
    if (s_q.mode[MODE_DO]) begin
      d_ok = s_q.rly_s[2];
      d_or = s_q.rly_s[2];
    end
    // and: all selected must hold (relay holds timers)
    // or: any selected keeps timing, clears when all end
    if (s_q.mode[MODE_AND]) begin
      crit = c_ok & s_ok & d_ok & (s_q.mode[2:0] != 3'h0);
    end else begin
      crit = c_or | s_or | d_or;
    end
  end

  // condition indication and forcing
  always_comb begin
    if (s_q.blocked) cond = COND_BLOCKED;
    else if (s_q.bf) cond = COND_BF;
    else if (s_q.retrip) cond = COND_RETRIP;
    else if (s_q.start) cond = COND_START;
    else cond = COND_NORMAL;
    if (s_q.frc_en) begin
      cond = s_q.frc;
    end
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    pickup = 1'b0;
    // synchronisers: first stage read only by the second
    s_d.blk_s = {s_q.blk_s[1:0], block_in};
    s_d.sig_s = {s_q.sig_s[1:0], signal_trip_in};
    s_d.rly_s = {s_q.rly_s[1:0], relay_trip_in};
    // program-cycle divider for the 5 ms time base
    s_d.tick = 1'b0;
    if (s_q.tcnt == TCNT_W'(TICK_LEN - 1)) begin
      s_d.tcnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tcnt = s_q.tcnt + 1'b1;
    end
    // evaluation once per program cycle
    if (s_q.tick) begin
      s_d.pu = pu_n;
      s_d.blk = s_q.blk_s[2];
      pickup = crit;
      if (pickup && !s_q.blk_s[2]) begin
        s_d.start = 1'b1;
        s_d.blocked = 1'b0;
        // both timers share the pick-up
        if (s_q.rt_cnt < s_q.rt_dly) s_d.rt_cnt = s_q.rt_cnt + 1'b1;
        if (s_q.bf_cnt < s_q.bf_dly) s_d.bf_cnt = s_q.bf_cnt + 1'b1;
        s_d.retrip = s_q.rt_en && (s_q.rt_cnt + 1'b1 >= s_q.rt_dly);
        s_d.bf = (s_q.bf_cnt + 1'b1 >= s_q.bf_dly);
      end else begin
        // blocked or released: timers, start, retrip and failure clear
        s_d.start = 1'b0;
        s_d.blocked = pickup;
        s_d.rt_cnt = '0;
        s_d.bf_cnt = '0;
        s_d.retrip = 1'b0;
        s_d.bf = 1'b0;
      end
    end
    if (!s_q.rt_en) s_d.retrip = 1'b0;
    // bus: one wait cycle, answer on the second
    s_d.ack = 1'b0;
    if ((avs_read_in || avs_write_in) && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdata = RD_UNMAPPED;
      unique case (avs_address_in)
        // condition at [18:16], force value at [10:8], gap bits read zero
        REG_CTRL: s_d.rdata = {13'h0000, cond, 5'h00, s_q.frc, s_q.frc_en, s_q.rt_en, s_q.res_sel, s_q.mode};
        REG_PH_SET: s_d.rdata = {16'h0000, s_q.ph_set};
        REG_RES_SET: s_d.rdata = {16'h0000, s_q.res_set};
        REG_RETRIP: s_d.rdata = {s_q.bf_dly[12:0], s_q.rt_dly};
        default: s_d.rdata = RD_UNMAPPED;
      endcase
      if (avs_write_in) begin
        // settings change takes effect while operating
        unique case (avs_address_in)
          REG_CTRL: begin
            s_d.mode = avs_writedata_in[F_MODE +: 4];
            s_d.res_sel = res_sel_t'(avs_writedata_in[F_RES +: 2]);
            s_d.rt_en = avs_writedata_in[F_RT_EN];
            s_d.frc_en = avs_writedata_in[F_FRC_EN];
            s_d.frc = cond_t'(avs_writedata_in[F_FRC +: 3]);
          end
          REG_PH_SET: s_d.ph_set = MAG_W'(avs_writedata_in[15:0] * PH_STEP);
          REG_RES_SET: s_d.res_set = MAG_W'(avs_writedata_in[15:0] * RES_STEP);
          REG_RETRIP: begin
            s_d.rt_dly = avs_writedata_in[DLY_W-1:0];
            // failure delay sits in the top bits, same place it reads back
            s_d.bf_dly = {6'h00, avs_writedata_in[31:DLY_W]};
          end
          default: s_d.ack = 1'b1;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
      s_q.mode <= MODE_RST;
      s_q.res_sel <= RES_OFF;
      s_q.rt_en <= 1'b1;
      s_q.frc <= COND_NORMAL;
      s_q.ph_set <= PH_SET_RST;
      s_q.res_set <= RES_SET_RST;
      s_q.rt_dly <= RETRIP_RST;
      s_q.bf_dly <= BF_RST;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  // outputs
  assign avs_waitrequest_out = !s_q.ack;
  assign avs_readdata_out = s_q.rdata;
  assign start_out = s_q.start;
  assign retrip_out = s_q.retrip;
  assign breaker_failure_output_out = s_q.bf;
  assign blocked_out = s_q.blocked;
  assign tick_out = s_q.tick;
  assign condition_out = cond;

endmodule // breaker_failure_protection
`default_nettype wire

// file: cbf_chk.sv
`timescale 1ns/100ps
`default_nettype none
module cbf_chk
  import cbf_pkg::*;
#(
  // program-cycle length in clocks, as in the design
  parameter int unsigned TICK_LEN = TICK_CYC
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // bus handshake
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // protection outputs
  input wire logic start_out,
  input wire logic retrip_out,
  input wire logic breaker_failure_output_out,
  input wire logic blocked_out,
  input wire logic tick_out
);
  logic [TCNT_W-1:0] cnt_q; // clocks since the last tick
  logic seen_q; // a first tick has been seen
  // counts the program-cycle length between ticks
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      seen_q <= 1'b0;
    end else if (tick_out) begin
      cnt_q <= '0;
      seen_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  a_bus_answer: assert property ($rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
    else $error("bus answer not one cycle after request");
  a_wait_one: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer held longer than one cycle");
  a_retrip_start: assert property (retrip_out |-> start_out)
    else $error("retrip without start");
  a_failure_start: assert property (breaker_failure_output_out |-> start_out)
    else $error("breaker failure without start");
  a_block_excl: assert property (blocked_out |-> !start_out)
    else $error("blocked and start together");
  a_tick_pulse: assert property (tick_out |=> !tick_out)
    else $error("tick longer than one clock");
  a_tick_gap: assert property (seen_q |-> cnt_q < TICK_LEN && (!tick_out || cnt_q == TICK_LEN - 1))
    else $error("program cycle length wrong");
  a_change_tick: assert property ($changed({start_out, retrip_out, blocked_out}) |-> tick_out || $past(tick_out))
    else $error("outputs changed away from a tick");
  c_start: cover property ($rose(start_out));
  c_retrip: cover property ($rose(retrip_out));
  c_block: cover property ($rose(blocked_out));
  c_failure: cover property ($rose(breaker_failure_output_out));
endmodule // cbf_chk
bind breaker_failure_protection cbf_chk #(.TICK_LEN(TICK_LEN)) u_chk (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .start_out(start_out),
  .retrip_out(retrip_out), .breaker_failure_output_out(breaker_failure_output_out),
  .blocked_out(blocked_out), .tick_out(tick_out));
`default_nettype wire

// file: cbf_frontend.sv
`timescale 1ns/100ps
`default_nettype none
module cbf_frontend
  import cbf_pkg::*;
(
  // clock, reset, program-cycle strobe
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic tick_in,
  // wanted a, b, c, residual one, residual two, calculated
  input wire logic [5:0][MAG_W-1:0] want_in,
  // magnitudes seen by the block
  output logic [5:0][MAG_W-1:0] mag_out
);
  // rms values refresh once per program cycle, never mid-cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      mag_out <= '0;
    end else if (tick_in) begin
      mag_out <= want_in;
    end
  end
endmodule // cbf_frontend
`default_nettype wire

// file: tb_breaker_failure_protection.sv
`timescale 1ns/100ps
`default_nettype none
module tb_breaker_failure_protection;
  import cbf_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic block_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, start_out, retrip_out, bf_out, blocked_out, tick_out;
  logic [2:0] condition_out;
  logic [5:0][MAG_W-1:0] want = '0;
  logic [5:0][MAG_W-1:0] mag;
  logic [31:0] rd_q[$]; // expected read data
  localparam int TB_TICK = 200; // shortened program cycle for the bench
  logic [3:0] ev_q[$]; // expected {start, retrip, failure, blocked}
  logic [3:0] last_ev = 4'h0;
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 19262;
  int n;
  always #25 mclk_in = ~mclk_in;
  breaker_failure_protection #(.TICK_LEN(TB_TICK)) DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1),
    .phase_a_mag_in(mag[0]), .phase_b_mag_in(mag[1]), .phase_c_mag_in(mag[2]),
    .residual_input_one_in(mag[3]), .residual_input_two_in(mag[4]), .calculated_residual_in(mag[5]),
    .block_in(block_in), .signal_trip_in(1'b0), .relay_trip_in(1'b0), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .start_out(start_out),
    .retrip_out(retrip_out), .breaker_failure_output_out(bf_out), .blocked_out(blocked_out),
    .tick_out(tick_out), .condition_out(condition_out));
  cbf_frontend u_fe (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .tick_in(tick_out), .want_in(want), .mag_out(mag));
  // one comparison, counted
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // verdict and end of run
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one bus transfer, held until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    // waitrequest is looked at on the rising edge; release only after it is low there
    do begin
      @(posedge mclk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 20);
    if (k >= 20) begin
      n_fail++;
      close_out;
    end
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // note the expected output set, then wait for it a bounded number of ticks
  task automatic wait_ev(input logic [3:0] v, input int lim);
    int k;
    k = 0;
    ev_q.push_back(v);
    while ({start_out, retrip_out, bf_out, blocked_out} !== v && k < lim * TB_TICK) begin
      @(negedge mclk_in);
      k++;
    end
    if (k >= lim * TB_TICK) begin
      n_fail++;
      close_out;
    end
  endtask
  // watcher: read answers and every change of start, retrip, failure and blocked
  always @(negedge mclk_in) begin
    if (avs_read_in && avs_waitrequest_out === 1'b0) begin
      check("readdata", rd_q.size() > 0 ? rd_q.pop_front() : 32'hFFFF_FFFF, avs_readdata_out);
    end
    if (rst_b_in && {start_out, retrip_out, bf_out, blocked_out} !== last_ev) begin
      last_ev = {start_out, retrip_out, bf_out, blocked_out};
      check("outputs", {28'h0, ev_q.size() > 0 ? ev_q.pop_front() : 4'hF}, {28'h0, last_ev});
    end
  end
  // main sequence
  initial begin
    repeat (8) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rd(4'h0, 32'h0000_0041);
    rd(4'h4, 32'h0000_00C8);
    rd(4'h8, 32'h0000_04B0);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0000_0000);
    n = 1 + ($unsigned($random(seed)) % 59);
    bus(1'b1, 4'h4, 32'(n));
    rd(4'h4, 32'(n * 10));
    // retrip 2 ticks, failure kept at 40 ticks in the top bits
    bus(1'b1, 4'hC, 32'h0140_0002); // retrip far below failure delay
    rd(4'hC, 32'h0140_0002);
    want[1] <= 16'h0258;
    wait_ev(4'h8, 4);
    wait_ev(4'hC, 3);
    block_in <= 1'b1; // raised just after a tick, well before the next
    wait_ev(4'h1, 2);
    rd(4'h0, 32'h0004_0041);
    want[1] <= 16'h0000;
    wait_ev(4'h0, 4);
    block_in <= 1'b0;
    want[0] <= 16'h0258;
    wait_ev(4'h8, 4);
    wait_ev(4'hC, 3);
    wait_ev(4'hE, 45);
    want[0] <= 16'h0000;
    wait_ev(4'h0, 4);
    repeat (20) @(posedge mclk_in);
    close_out;
  end
endmodule // tb_breaker_failure_protection
`default_nettype wire
